/* File: shared/exec_alu_defs.svh */
// offsets, field positions, reset values and timing counts of the execute datapath
// assumes a 32-bit classic wishbone slave with byte addresses on 10 bits
`ifndef EXEC_ALU_DEFS_SVH
`define EXEC_ALU_DEFS_SVH
// ==========================================
// register byte addresses
`define REG_CMD 10'h000
`define REG_OPND 10'h004
`define REG_WORK 10'h008
`define REG_FLAGS 10'h00c
`define REG_PC 10'h010
`define REG_WDOG 10'h014
`define REG_STACK 10'h018
`define RAM_REGION 2'b01
// ==========================================
// field positions
`define CMD_OP_LSB 0
`define CMD_BIT_LSB 8
`define CMD_WAKE_BIT 31
`define OPND_ADDR_LSB 0
`define OPND_IMM_LSB 8
`define OPND_TGT_LSB 16
// ==========================================
// reset values and constants
`define WORK_RST 8'h00
`define PC_RST 10'h000
`define FLAGS_RST 6'h00
`define PCL_ADDR 6'h02
`define RAM_WORDS 64
`define STACK_LEVELS 4
// ==========================================
// timing counts in system clocks
`define INSTR_CLKS 4'h4
`define WDOG_PRESCALE 8'hff
`endif

/* File: shared/exec_alu_pkg.sv */
// types shared by the execute datapath and its bench
// assumes the defines header is compiled alongside
package exec_alu_pkg;
   // ==========================================
   // instruction selector
   typedef enum logic [4:0] {
      OP_NOP, OP_ADD_CARRY_W, OP_ADD_CARRY_M, OP_ADD_W, OP_ADD_IMM,
      OP_ADD_M, OP_AND_W, OP_AND_IMM, OP_AND_M, OP_CALL, OP_CLEAR_M,
      OP_CLEAR_BIT, OP_KICK, OP_HALF_FIRST, OP_HALF_SECOND, OP_INVERT_M,
      OP_INVERT_W, OP_BCD_FIX, OP_STEP_DOWN_M, OP_STEP_DOWN_W,
      OP_STEP_UP_M, OP_STEP_UP_W, OP_POWER_DOWN, OP_GOTO
   } opcode_t;
   typedef enum {ST_IDLE, ST_EXEC} state_t;
   // ==========================================
   // status flags, expiry in bit 5 down to carry in bit 0
   typedef struct packed {
      logic expiry;
      logic powerdown;
      logic signed_wrap;
      logic zero;
      logic half_carry;
      logic carry;
   } flags_t;
   typedef struct packed {
      opcode_t op;
      logic [2:0] bit_idx;
      logic [5:0] mem_addr;
      logic [7:0] imm;
      logic [9:0] target;
   } cmd_t;
endpackage

/* File: logic/instr_exec_alu.sv */
// instruction execute datapath: working register, data memory, pc, return stack, watchdog
// assumes a classic wishbone master; one instruction cycle is four system clocks
//
// Summary of operation
// - add with carry: work plus memory plus carry into work, four flags
// - add with carry into memory byte, four arithmetic flags updated
// - add memory or immediate to work, result in work, four flags
// - add work to memory byte without carry, sum into memory
// - and of work with memory into work, the immediate form also ands memory, not the immediate, zero flag only
// - and into memory byte, zero flag only
// - call pushes next address, loads target, flags untouched
// - clear memory writes zero, no flag changes
// - clear bit zeroes one bit, other bits kept, no flags
// - watchdog kick clears counter, powerdown and expiry flags
// - half kicks only record; both together clear counter and flags
// - invert memory byte in place, zero flag only
// - invert memory into work, memory kept, zero flag only
// - bcd low nibble adds six above nine or half carry, spill set only without half carry
// - bcd high nibble adds spill, then six above nine or carry, sets carry when adjusting
// - bcd result goes to memory, only carry may change
// - step down subtracts one into memory or work, zero flag only
// - step up adds one into memory or work, zero flag only
// - power down advances pc, halts execution, stops clock, keeps state
// - power down clears watchdog and prescaler, sets powerdown, clears expiry
// - goto loads pc with target, no push, no flags
// - pc low byte destination adds one instruction cycle of four clocks
`timescale 1ns/1ps
`include "exec_alu_defs.svh"
module instr_exec_alu (
   input wire logic I_CLOCK,
   input wire logic I_RESET,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [9:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   output logic O_BUSY,
   output logic O_CLOCK_STOP
);
   // ==========================================
   // functions
   // result {carry, half carry, signed wrap, sum}
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
      logic [8:0] s;
      logic [4:0] l;
      logic ov;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      ov = (a[7] == b[7]) && (s[7] != a[7]);
      return {s[8], l[4], ov, s[7:0]};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mem_dest(input exec_alu_pkg::opcode_t op);
      case (op)
         exec_alu_pkg::OP_ADD_CARRY_M, exec_alu_pkg::OP_ADD_M, exec_alu_pkg::OP_AND_M,
         exec_alu_pkg::OP_CLEAR_M, exec_alu_pkg::OP_CLEAR_BIT, exec_alu_pkg::OP_INVERT_M,
         exec_alu_pkg::OP_BCD_FIX, exec_alu_pkg::OP_STEP_DOWN_M, exec_alu_pkg::OP_STEP_UP_M: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // ==========================================
   // state
   exec_alu_pkg::state_t state_reg, state_next;
   exec_alu_pkg::cmd_t cmd_reg, cmd_next;
   exec_alu_pkg::flags_t flags_reg, flags_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] work_reg, work_next;
   logic [9:0] pc_reg, pc_next;
   logic [9:0] stack_reg [`STACK_LEVELS];
   logic [9:0] stack_next [`STACK_LEVELS];
   logic [1:0] sp_reg, sp_next;
   logic halted_reg, halted_next;
   logic [7:0] wdog_reg, wdog_next;
   logic [7:0] presc_reg, presc_next;
   logic half1_reg, half1_next, half2_reg, half2_next;
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic [7:0] ram [`RAM_WORDS];
   logic mem_we;
   logic [5:0] mem_wa;
   logic [7:0] mem_wd;
   logic req, wr, start, commit, long_op;
   logic [7:0] operand, res, bval;
   logic [10:0] sum;
   logic dst_mem, wd_clear, spill;
   logic [4:0] lo5, hi5;
   logic [31:0] opnd_merged;
   exec_alu_pkg::opcode_t new_op;

   assign req = I_WB_CYC && I_WB_STB && !ack_reg;
   assign wr = req && I_WB_WE;
   assign new_op = exec_alu_pkg::opcode_t'(I_WB_DAT[`CMD_OP_LSB +: 5]);
   assign start = wr && I_WB_ADR == `REG_CMD && I_WB_SEL[0] && state_reg == exec_alu_pkg::ST_IDLE && !halted_reg;
   assign commit = state_reg == exec_alu_pkg::ST_EXEC && cnt_reg == 4'h0;
   // the pc low byte sits in the instruction data map, so instruction reads of it see the pc; bus reads see the ram
   assign operand = (cmd_reg.mem_addr == `PCL_ADDR) ? pc_reg[7:0] : ram[cmd_reg.mem_addr];
   assign long_op = new_op == exec_alu_pkg::OP_CALL || new_op == exec_alu_pkg::OP_GOTO
      || (mem_dest(new_op) && cmd_reg.mem_addr == `PCL_ADDR);
   assign bval = (cmd_reg.op == exec_alu_pkg::OP_ADD_IMM) ? cmd_reg.imm : operand;
   assign sum = add8(work_reg, bval, (cmd_reg.op == exec_alu_pkg::OP_ADD_CARRY_W
      || cmd_reg.op == exec_alu_pkg::OP_ADD_CARRY_M) ? flags_reg.carry : 1'b0);

   // ==========================================
   // execution and watchdog next state
   always_comb begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      flags_next = flags_reg;
      cnt_next = cnt_reg;
      work_next = work_reg;
      pc_next = pc_reg;
      stack_next = stack_reg;
      sp_next = sp_reg;
      halted_next = halted_reg;
      wdog_next = wdog_reg;
      presc_next = presc_reg;
      half1_next = half1_reg;
      half2_next = half2_reg;
      mem_we = 1'b0;
      mem_wa = I_WB_ADR[7:2];
      mem_wd = I_WB_DAT[7:0];
      res = 8'h00;
      dst_mem = 1'b0;
      wd_clear = 1'b0;
      spill = 1'b0;
      lo5 = 5'h00;
      hi5 = 5'h00;
      opnd_merged = 32'h0000_0000;
      // operands and ram can only change between instructions
      if (wr && state_reg == exec_alu_pkg::ST_IDLE) begin
         if (I_WB_ADR[9:8] == `RAM_REGION) begin
            mem_we = I_WB_SEL[0];
         end
         case (I_WB_ADR)
            `REG_OPND: begin
               opnd_merged = merge({6'h00, cmd_reg.target, cmd_reg.imm, 2'b00, cmd_reg.mem_addr}, I_WB_DAT,
                  I_WB_SEL);
               cmd_next.mem_addr = opnd_merged[`OPND_ADDR_LSB +: 6];
               cmd_next.imm = opnd_merged[`OPND_IMM_LSB +: 8];
               cmd_next.target = opnd_merged[`OPND_TGT_LSB +: 10];
            end
            `REG_WORK: if (I_WB_SEL[0]) begin
               work_next = I_WB_DAT[7:0];
            end
            `REG_FLAGS: if (I_WB_SEL[0]) begin
               flags_next[3:0] = I_WB_DAT[3:0];
            end
            default: begin
            end
         endcase
      end
      if (wr && I_WB_ADR == `REG_CMD && I_WB_SEL[3] && I_WB_DAT[`CMD_WAKE_BIT]) begin
         halted_next = 1'b0;
      end
      if (start) begin
         cmd_next.op = new_op;
         cmd_next.bit_idx = I_WB_DAT[`CMD_BIT_LSB +: 3];
         state_next = exec_alu_pkg::ST_EXEC;
         cnt_next = long_op ? (`INSTR_CLKS + `INSTR_CLKS - 4'h1) : (`INSTR_CLKS - 4'h1);
      end
      if (state_reg == exec_alu_pkg::ST_EXEC) begin
         cnt_next = cnt_reg - 4'h1;
      end
      if (commit) begin
         state_next = exec_alu_pkg::ST_IDLE;
         pc_next = pc_reg + 10'h001;
         dst_mem = mem_dest(cmd_reg.op);
         case (cmd_reg.op)
            exec_alu_pkg::OP_ADD_CARRY_W, exec_alu_pkg::OP_ADD_W, exec_alu_pkg::OP_ADD_IMM: begin
               work_next = sum[7:0];
               flags_next.carry = sum[10];
               flags_next.half_carry = sum[9];
               flags_next.signed_wrap = sum[8];
               flags_next.zero = sum[7:0] == 8'h00;
            end
            exec_alu_pkg::OP_ADD_CARRY_M, exec_alu_pkg::OP_ADD_M: begin
               res = sum[7:0];
               flags_next.carry = sum[10];
               flags_next.half_carry = sum[9];
               flags_next.signed_wrap = sum[8];
               flags_next.zero = sum[7:0] == 8'h00;
            end
            exec_alu_pkg::OP_AND_W, exec_alu_pkg::OP_AND_IMM: begin
               res = work_reg & bval;
               work_next = res;
               flags_next.zero = res == 8'h00;
            end
            exec_alu_pkg::OP_AND_M: begin
               res = work_reg & operand;
               flags_next.zero = res == 8'h00;
            end
            exec_alu_pkg::OP_CALL: begin
               stack_next[sp_reg] = pc_reg + 10'h001;
               sp_next = sp_reg + 2'h1;
               pc_next = cmd_reg.target;
            end
            exec_alu_pkg::OP_CLEAR_M: begin
               res = 8'h00;
            end
            exec_alu_pkg::OP_CLEAR_BIT: begin
               res = operand & ~(8'h01 << cmd_reg.bit_idx);
            end
            exec_alu_pkg::OP_KICK: begin
               wd_clear = 1'b1;
            end
            exec_alu_pkg::OP_HALF_FIRST: begin
               half1_next = 1'b1;
               wd_clear = half2_reg;
            end
            exec_alu_pkg::OP_HALF_SECOND: begin
               half2_next = 1'b1;
               wd_clear = half1_reg;
            end
            exec_alu_pkg::OP_INVERT_M: begin
               res = ~operand;
               flags_next.zero = res == 8'h00;
            end
            exec_alu_pkg::OP_INVERT_W: begin
               work_next = ~operand;
               flags_next.zero = operand == 8'hff;
            end
            exec_alu_pkg::OP_BCD_FIX: begin
               if (work_reg[3:0] > 4'h9 || flags_reg.half_carry) begin
                  lo5 = {1'b0, work_reg[3:0]} + 5'h06;
                  spill = !flags_reg.half_carry;
               end else begin
                  lo5 = {1'b0, work_reg[3:0]};
                  spill = 1'b0;
               end
               hi5 = {1'b0, work_reg[7:4]} + {4'h0, spill};
               if (hi5 > 5'h09 || flags_reg.carry) begin
                  hi5 = hi5 + 5'h06;
                  flags_next.carry = 1'b1;
               end
               res = {hi5[3:0], lo5[3:0]};
            end
            exec_alu_pkg::OP_STEP_DOWN_M, exec_alu_pkg::OP_STEP_DOWN_W: begin
               res = operand - 8'h01;
               flags_next.zero = res == 8'h00;
               if (cmd_reg.op == exec_alu_pkg::OP_STEP_DOWN_W) begin
                  work_next = res;
               end
            end
            exec_alu_pkg::OP_STEP_UP_M, exec_alu_pkg::OP_STEP_UP_W: begin
               res = operand + 8'h01;
               flags_next.zero = res == 8'h00;
               if (cmd_reg.op == exec_alu_pkg::OP_STEP_UP_W) begin
                  work_next = res;
               end
            end
            exec_alu_pkg::OP_POWER_DOWN: begin
               halted_next = 1'b1;
            end
            exec_alu_pkg::OP_GOTO: begin
               pc_next = cmd_reg.target;
            end
            default: begin
            end
         endcase
         if (dst_mem) begin
            if (cmd_reg.mem_addr == `PCL_ADDR) begin
               pc_next = {pc_reg[9:8], res};
            end else begin
               mem_we = 1'b1;
               mem_wa = cmd_reg.mem_addr;
               mem_wd = res;
            end
         end
      end
      // watchdog prescaler keeps running while halted so expiry can wake the core
      presc_next = presc_reg + 8'h01;
      if (presc_reg == `WDOG_PRESCALE) begin
         presc_next = 8'h00;
         wdog_next = wdog_reg + 8'h01;
      end
      if (wd_clear) begin
         wdog_next = 8'h00;
         presc_next = 8'h00;
         flags_next.powerdown = 1'b0;
         flags_next.expiry = 1'b0;
         half1_next = 1'b0;
         half2_next = 1'b0;
      end
      if (commit && cmd_reg.op == exec_alu_pkg::OP_POWER_DOWN) begin
         wdog_next = 8'h00;
         presc_next = 8'h00;
         flags_next.powerdown = 1'b1;
         flags_next.expiry = 1'b0;
      end
      // expiry is applied last so a same-cycle kick cannot hide it
      if (presc_reg == `WDOG_PRESCALE && wdog_reg == 8'hff) begin
         flags_next.expiry = 1'b1;
         halted_next = 1'b0;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RESET) begin
      if (I_RESET) begin
         state_reg <= exec_alu_pkg::ST_IDLE;
         cmd_reg <= '0;
         flags_reg <= `FLAGS_RST;
         cnt_reg <= 4'h0;
         work_reg <= `WORK_RST;
         pc_reg <= `PC_RST;
         for (int i = 0; i < `STACK_LEVELS; i++) begin
            stack_reg[i] <= 10'h000;
         end
         sp_reg <= 2'h0;
         halted_reg <= 1'b0;
         wdog_reg <= 8'h00;
         presc_reg <= 8'h00;
         half1_reg <= 1'b0;
         half2_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         flags_reg <= flags_next;
         cnt_reg <= cnt_next;
         work_reg <= work_next;
         pc_reg <= pc_next;
         stack_reg <= stack_next;
         sp_reg <= sp_next;
         halted_reg <= halted_next;
         wdog_reg <= wdog_next;
         presc_reg <= presc_next;
         half1_reg <= half1_next;
         half2_reg <= half2_next;
      end
   end

   // data memory has no reset; software must initialise it
   always_ff @(posedge I_CLOCK) begin
      if (mem_we) begin
         ram[mem_wa] <= mem_wd;
      end
   end

   // ==========================================
   // wishbone answer, one cycle after the request
   always_comb begin
      ack_next = req;
      rdat_next = 32'h0000_0000;
      if (req && !I_WB_WE) begin
         if (I_WB_ADR[9:8] == `RAM_REGION) begin
            rdat_next = {24'h000000, ram[I_WB_ADR[7:2]]};
         end else begin
            case (I_WB_ADR)
               `REG_CMD: rdat_next = {30'h0, halted_reg, state_reg == exec_alu_pkg::ST_EXEC};
               `REG_OPND: rdat_next = {6'h00, cmd_reg.target, cmd_reg.imm, 2'b00, cmd_reg.mem_addr};
               `REG_WORK: rdat_next = {24'h000000, work_reg};
               `REG_FLAGS: rdat_next = {26'h0, flags_reg};
               `REG_PC: rdat_next = {22'h0, pc_reg};
               `REG_WDOG: rdat_next = {24'h000000, wdog_reg};
               `REG_STACK: rdat_next = {20'h0, sp_reg, stack_reg[sp_reg - 2'h1]};
               default: rdat_next = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RESET) begin
      if (I_RESET) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   assign O_WB_ACK = ack_reg;
   assign O_WB_DAT = rdat_reg;
   assign O_BUSY = state_reg == exec_alu_pkg::ST_EXEC;
   assign O_CLOCK_STOP = halted_reg;

   // ==========================================
   // assertions
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RESET);

   property p_add_w;
      commit && cmd_reg.op == exec_alu_pkg::OP_ADD_W
         |=> {flags_reg.carry, work_reg} == $past({1'b0, work_reg} + {1'b0, operand});
   endproperty
   a_add_w: assert property (p_add_w) else $error("add result or carry wrong");
   property p_and_flags;
      commit && cmd_reg.op == exec_alu_pkg::OP_AND_W |=> flags_reg.zero == (work_reg == 8'h00)
         && flags_reg[3] == $past(flags_reg[3]) && flags_reg[1:0] == $past(flags_reg[1:0]);
   endproperty
   a_and_flags: assert property (p_and_flags) else $error("and touched wrong flags");
   property p_clear;
      commit && cmd_reg.op == exec_alu_pkg::OP_CLEAR_M && cmd_reg.mem_addr != `PCL_ADDR
         |=> ram[cmd_reg.mem_addr] == 8'h00 && $stable(flags_reg);
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");
   property p_call;
      commit && cmd_reg.op == exec_alu_pkg::OP_CALL |=> pc_reg == $past(cmd_reg.target)
         && stack_reg[$past(sp_reg)] == $past(pc_reg) + 10'h001;
   endproperty
   a_call: assert property (p_call) else $error("call push or load wrong");
   property p_goto;
      commit && cmd_reg.op == exec_alu_pkg::OP_GOTO |=> pc_reg == $past(cmd_reg.target) && $stable(sp_reg);
   endproperty
   a_goto: assert property (p_goto) else $error("goto wrong");
   property p_kick;
      commit && cmd_reg.op == exec_alu_pkg::OP_KICK |=> !flags_reg.powerdown && wdog_reg == 8'h00;
   endproperty
   a_kick: assert property (p_kick) else $error("kick did not clear");
   property p_half;
      commit && cmd_reg.op == exec_alu_pkg::OP_HALF_FIRST && !half2_reg |=> $stable(flags_reg.powerdown) ##0 half1_reg;
   endproperty
   a_half: assert property (p_half) else $error("lone half kick acted");
   property p_halt;
      commit && cmd_reg.op == exec_alu_pkg::OP_POWER_DOWN |=> O_CLOCK_STOP && flags_reg.powerdown
         && presc_reg == 8'h00 && pc_reg == $past(pc_reg) + 10'h001;
   endproperty
   a_halt: assert property (p_halt) else $error("power down wrong");
   property p_short;
      start && !long_op |=> !commit [*3] ##1 commit;
   endproperty
   a_short: assert property (p_short) else $error("instruction not four clocks");
   property p_long;
      start && long_op |=> !commit [*7] ##1 commit;
   endproperty
   a_long: assert property (p_long) else $error("long instruction not eight clocks");
   property p_step_up;
      commit && cmd_reg.op == exec_alu_pkg::OP_STEP_UP_W |=> work_reg == $past(operand) + 8'h01;
   endproperty
   a_step_up: assert property (p_step_up) else $error("step up wrong");

   c_call: cover property (commit && cmd_reg.op == exec_alu_pkg::OP_CALL);
   c_bcd: cover property (commit && cmd_reg.op == exec_alu_pkg::OP_BCD_FIX && flags_next.carry);
   c_halt: cover property (commit && cmd_reg.op == exec_alu_pkg::OP_POWER_DOWN);
   c_long: cover property (start && long_op && new_op != exec_alu_pkg::OP_GOTO);
endmodule

/* File: sim/instr_exec_alu_tb_top.sv */
// self-checking bench for the execute datapath, driven over classic wishbone
// assumes the design answers every request and lowers busy when an instruction commits
`timescale 1ns/1ps
`include "exec_alu_defs.svh"
module instr_exec_alu_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic busy;
   logic stop;
   int err_count = 0;
   int cmp_count = 0;
   int ex_cycles = 0;
   instr_exec_alu i_dut (.I_CLOCK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
      .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .O_BUSY(busy), .O_CLOCK_STOP(stop));
   initial begin
      forever #4 clk = ~clk;
   end
   // ==========================================
   // bus tasks
   // called just after a rising edge; ack and data are seen as they stood at the edge
   task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
         output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (ack !== 1'b1) begin
         err_count++;
         $display("mismatch t=%0t no ack adr=%h", $time, a);
      end
      // one idle cycle between requests
      @(posedge clk);
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] e);
      cmp_count++;
      if (got !== e) begin
         err_count++;
         $display("mismatch t=%0t got %h exp %h", $time, got, e);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, 4'hf, q);
   endtask
   task automatic chk(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, 4'hf, q);
      cmp(q, e);
   endtask
   function automatic logic [9:0] ram(input int i);
      return 10'h100 + 10'(4 * i);
   endfunction
   task automatic ex(input logic [4:0] op, input logic [2:0] b, input logic [5:0] m, input logic [7:0] imm,
         input logic [9:0] t);
      int n;
      wr(`REG_OPND, {6'h00, t, imm, 2'b00, m});
      wr(`REG_CMD, {21'h000000, b, 3'b000, op});
      n = 0;
      while (busy !== 1'b0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      // short ops end three edges after the command returns, long ones seven
      ex_cycles = n;
      if (busy !== 1'b0) begin
         err_count++;
         $display("mismatch t=%0t instruction never finished", $time);
      end
   endtask
   task automatic wake();
      logic [31:0] q;
      wb(1'b1, `REG_CMD, 32'h80000000, 4'h8, q);
   endtask
   task automatic close_out();
      if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      close_out();
   end
   // ==========================================
   // tests
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      chk(10'h3fc, 32'h0); // unmapped place reads zero
      wr(ram(5), 32'h7f); wr(`REG_WORK, 32'h01);
      ex(exec_alu_pkg::OP_ADD_W, 3'h0, 6'h05, 8'h00, 10'h000);
      chk(`REG_WORK, 32'h80); chk(`REG_FLAGS, 32'h0a);
      cmp(ex_cycles, 32'h3);
      wr(`REG_FLAGS, 32'h01);
      ex(exec_alu_pkg::OP_ADD_CARRY_M, 3'h0, 6'h05, 8'h00, 10'h000);
      chk(ram(5), 32'h00); chk(`REG_FLAGS, 32'h07); chk(`REG_WORK, 32'h80);
      wr(`REG_FLAGS, 32'h0b);
      ex(exec_alu_pkg::OP_AND_IMM, 3'h0, 6'h05, 8'h0f, 10'h000);
      chk(`REG_WORK, 32'h00); chk(`REG_FLAGS, 32'h0f);
      ex(exec_alu_pkg::OP_INVERT_W, 3'h0, 6'h05, 8'h00, 10'h000);
      chk(`REG_WORK, 32'hff); chk(`REG_FLAGS, 32'h0b); chk(ram(5), 32'h00);
      wr(ram(6), 32'h01);
      ex(exec_alu_pkg::OP_STEP_DOWN_M, 3'h0, 6'h06, 8'h00, 10'h000);
      chk(ram(6), 32'h00); chk(`REG_FLAGS, 32'h0f);
      wr(ram(6), 32'hff);
      ex(exec_alu_pkg::OP_CLEAR_BIT, 3'h7, 6'h06, 8'h00, 10'h000);
      chk(ram(6), 32'h7f); chk(`REG_FLAGS, 32'h0f);
      wr(`REG_WORK, 32'h9a); wr(`REG_FLAGS, 32'h00);
      ex(exec_alu_pkg::OP_BCD_FIX, 3'h0, 6'h07, 8'h00, 10'h000);
      chk(ram(7), 32'h00); chk(`REG_FLAGS, 32'h01); chk(`REG_WORK, 32'h9a);
      ex(exec_alu_pkg::OP_CALL, 3'h0, 6'h00, 8'h00, 10'h123);
      chk(`REG_PC, 32'h123); chk(`REG_STACK, 32'h408);
      cmp(ex_cycles, 32'h7);
      ex(exec_alu_pkg::OP_GOTO, 3'h0, 6'h00, 8'h00, 10'h055);
      chk(`REG_PC, 32'h055); chk(`REG_STACK, 32'h408);
      ex(exec_alu_pkg::OP_POWER_DOWN, 3'h0, 6'h00, 8'h00, 10'h000);
      chk(`REG_PC, 32'h056); chk(`REG_CMD, 32'h2);
      chk(`REG_FLAGS, 32'h11); chk(`REG_WDOG, 32'h0);
      cmp(stop, 32'h1);
      // a command while halted must not run
      ex(exec_alu_pkg::OP_GOTO, 3'h0, 6'h00, 8'h00, 10'h3ff);
      chk(`REG_PC, 32'h056);
      wake();
      cmp(stop, 32'h0);
      ex(exec_alu_pkg::OP_KICK, 3'h0, 6'h00, 8'h00, 10'h000);
      chk(`REG_FLAGS, 32'h01);
      ex(exec_alu_pkg::OP_POWER_DOWN, 3'h0, 6'h00, 8'h00, 10'h000);
      wake();
      ex(exec_alu_pkg::OP_HALF_FIRST, 3'h0, 6'h00, 8'h00, 10'h000);
      chk(`REG_FLAGS, 32'h11);
      ex(exec_alu_pkg::OP_HALF_SECOND, 3'h0, 6'h00, 8'h00, 10'h000);
      chk(`REG_FLAGS, 32'h01); chk(`REG_PC, 32'h05a);
      ex(exec_alu_pkg::OP_ADD_CARRY_W, 3'h0, 6'h06, 8'h00, 10'h000);
      chk(`REG_WORK, 32'h1a); chk(`REG_FLAGS, 32'h03);
      ex(exec_alu_pkg::OP_ADD_M, 3'h0, 6'h06, 8'h00, 10'h000);
      chk(ram(6), 32'h99); chk(`REG_FLAGS, 32'h0a); chk(`REG_WORK, 32'h1a);
      ex(exec_alu_pkg::OP_AND_M, 3'h0, 6'h06, 8'h00, 10'h000);
      chk(ram(6), 32'h18); chk(`REG_FLAGS, 32'h0a);
      ex(exec_alu_pkg::OP_INVERT_M, 3'h0, 6'h06, 8'h00, 10'h000);
      chk(ram(6), 32'he7); chk(`REG_FLAGS, 32'h0a);
      ex(exec_alu_pkg::OP_STEP_UP_W, 3'h0, 6'h06, 8'h00, 10'h000);
      chk(`REG_WORK, 32'he8); chk(ram(6), 32'he7);
      ex(exec_alu_pkg::OP_CLEAR_M, 3'h0, 6'h06, 8'h00, 10'h000);
      chk(ram(6), 32'h00); chk(`REG_FLAGS, 32'h0a); chk(`REG_PC, 32'h060);
      // clearing the pc low byte takes the long path
      ex(exec_alu_pkg::OP_CLEAR_M, 3'h0, 6'h02, 8'h00, 10'h000);
      cmp(ex_cycles, 32'h7); chk(`REG_PC, 32'h000);
      close_out();
   end
endmodule
